// File: rtl/converter_status_consts.svh
// Constants for the converter status register and its serial command decoder.
`ifndef CONVERTER_STATUS_CONSTS_SVH
`define CONVERTER_STATUS_CONSTS_SVH
// ----------------------------------------------------------------------------
// Register layout
// ----------------------------------------------------------------------------
`define CST_OFFSET 3'h0
`define CST_RESET 8'h80
`define CST_RDY_BIT 7
`define CST_ERR_BIT 6
`define CST_MISSING_REFERENCE_FLAG_BIT 5
`define CST_PARITY_BIT 4
`define CST_CHAN_MSB 3
// ----------------------------------------------------------------------------
// Register select codes and sizes in bits
// ----------------------------------------------------------------------------
`define RSEL_STATUS 3'h0
`define RSEL_DATA 3'h3
`define RSEL_ID 3'h4
`define RSEL_GPO 3'h5
`define SIZE_BYTE 6'h08
`define SIZE_WORD 6'h18
`define SIZE_APPENDED 6'h20
`endif

// File: rtl/converter_status_pkg.sv
// Types shared by the converter status register design.
`default_nettype none
package converter_status_pkg;
  typedef enum logic [1:0] {
    LINK_WAIT,
    LINK_CMD,
    LINK_SKIP,
    LINK_SEND
  } link_state_t;
endpackage
`default_nettype wire

// File: rtl/converter_status.sv
// Converter status register with its serial command decoder and shift-out path.
`include "converter_status_consts.svh"
`default_nettype none
// Operation
// - 8-bit read-only status, resets to 0x80
// - Status shifted out MSB first
// - New result clears ready bit
// - Data read or pre-update sets ready bit
// - Power-down, idle or sync low set ready
// - Serial output pin shows ready between transfers
// - Error flag marks clamped results
// - Error clears on in-range result
// - Calibration reference faults, or range faults in system calibration, set error
// - Missing reference flag, results clamp to ones
// - Parity flag shows odd data ones
// - Appending sends status after data
module converter_status
  import converter_status_pkg::*;
#(
  parameter int DATA_W = 24,
  parameter int CHAN_W = 4
) (
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic SCLK_I,
  input wire logic DIN_I,
  input wire logic SYNC_N_I,
  input wire logic REF_BELOW_I,
  input wire logic RESULT_WRITE_I,
  input wire logic [DATA_W-1:0] RESULT_DATA_I,
  input wire logic RESULT_CLAMPED_I,
  input wire logic [CHAN_W-1:0] RESULT_CHANNEL_I,
  input wire logic UPDATE_WARN_I,
  input wire logic POWER_IDLE_I,
  input wire logic CAL_ACTIVE_I,
  input wire logic CAL_SYSTEM_I,
  input wire logic CAL_REF_BAD_I,
  input wire logic CAL_RANGE_BAD_I,
  input wire logic PARITY_CHECK_ENABLE_I,
  input wire logic APPEND_STATUS_ENABLE_I,
  output logic DOUT_RDY_N_O,
  output logic [7:0] STATUS_O,
  output logic [DATA_W-1:0] DATA_O
);
  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  logic [3:0] meta_r;
  logic [3:0] sync_r;
  logic sclk_prev_r;
  logic sclk_rise;
  logic sclk_fall;
  logic din_s;
  logic sync_n_s;
  logic missing_reference_flag_s;

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      // Synchronisers reset to the idle pin levels, so no false edge or flag follows reset.
      meta_r <= 4'h7;
      sync_r <= 4'h7;
      sclk_prev_r <= 1'b1;
    end else begin
      meta_r <= {REF_BELOW_I, SYNC_N_I, DIN_I, SCLK_I};
      sync_r <= meta_r;
      sclk_prev_r <= sync_r[0];
    end
  end

  assign sclk_rise = sync_r[0] & ~sclk_prev_r;
  assign sclk_fall = ~sync_r[0] & sclk_prev_r;
  assign din_s = sync_r[1];
  assign sync_n_s = sync_r[2];
  assign missing_reference_flag_s = sync_r[3];

  // --------------------------------------------------------------------------
  // Command decoder and shift-out
  // --------------------------------------------------------------------------
  link_state_t state_r;
  logic [6:0] cmd_r;
  logic [5:0] cnt_r;
  logic [31:0] tx_r;
  logic dout_r;
  logic send_data_r;
  logic data_read_done;
  logic [6:0] cmd_nxt;
  logic [2:0] rsel_nxt;
  logic [7:0] status;
  logic rdy_n_r;
  logic err_r;
  logic parity_r;
  logic [CHAN_W-1:0] chan_r;
  logic [DATA_W-1:0] data_r;

  assign cmd_nxt = {cmd_r[5:0], din_s};
  assign rsel_nxt = cmd_nxt[5:3];
  assign data_read_done = (state_r == LINK_SEND) && sclk_rise && (cnt_r == 6'h01) &&
    send_data_r;

  function automatic logic [5:0] reg_size(input logic [2:0] rsel);
    unique case (rsel)
      `RSEL_STATUS, `RSEL_ID, `RSEL_GPO: reg_size = `SIZE_BYTE;
      default: reg_size = `SIZE_WORD;
    endcase
  endfunction

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_r <= LINK_WAIT;
      cmd_r <= 7'h00;
      cnt_r <= 6'h00;
      tx_r <= 32'h0000_0000;
      send_data_r <= 1'b0;
    end else if (sclk_rise) begin
      unique case (state_r)
        LINK_WAIT: begin
          if (!din_s) begin
            state_r <= LINK_CMD;
            cnt_r <= 6'h07;
          end
        end
        LINK_CMD: begin
          cmd_r <= cmd_nxt;
          cnt_r <= cnt_r - 6'h01;
          if (cnt_r == 6'h01) begin
            send_data_r <= cmd_nxt[6] && (rsel_nxt == `RSEL_DATA);
            if (!cmd_nxt[6]) begin
              // A write to the command register itself carries no payload.
              state_r <= (rsel_nxt == `RSEL_STATUS) ? LINK_WAIT : LINK_SKIP;
              cnt_r <= reg_size(rsel_nxt);
            end else if (rsel_nxt == `RSEL_STATUS) begin
              state_r <= LINK_SEND;
              tx_r <= {status, 24'h00_0000};
              cnt_r <= `SIZE_BYTE;
            end else if (rsel_nxt == `RSEL_DATA) begin
              state_r <= LINK_SEND;
              tx_r <= {data_r, status};
              cnt_r <= APPEND_STATUS_ENABLE_I ? `SIZE_APPENDED : `SIZE_WORD;
            end else begin
              // Other registers live elsewhere; they shift out as zeros here.
              state_r <= LINK_SEND;
              tx_r <= 32'h0000_0000;
              cnt_r <= reg_size(rsel_nxt);
            end
          end
        end
        LINK_SKIP, LINK_SEND: begin
          cnt_r <= cnt_r - 6'h01;
          if (cnt_r == 6'h01) begin
            state_r <= LINK_WAIT;
          end
        end
      endcase
    end else if (sclk_fall && state_r == LINK_SEND) begin
      tx_r <= {tx_r[30:0], 1'b0};
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      dout_r <= 1'b1;
    end else if (state_r == LINK_SEND) begin
      if (sclk_fall) begin
        dout_r <= tx_r[31];
      end
    end else begin
      // Between transfers the pin mirrors the ready bit for pin polling.
      dout_r <= rdy_n_r;
    end
  end

  // --------------------------------------------------------------------------
  // Status flags
  // --------------------------------------------------------------------------
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rdy_n_r <= 1'b1;
    end else if (RESULT_WRITE_I) begin
      // A fresh result outranks a set in the same cycle, else it would be lost.
      rdy_n_r <= 1'b0;
    end else if (data_read_done || UPDATE_WARN_I) begin
      rdy_n_r <= 1'b1;
    end else if (POWER_IDLE_I || !sync_n_s) begin
      rdy_n_r <= 1'b1;
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      err_r <= 1'b0;
    end else if (CAL_ACTIVE_I && (CAL_REF_BAD_I || (CAL_SYSTEM_I && CAL_RANGE_BAD_I))) begin
      err_r <= 1'b1;
    end else if (RESULT_WRITE_I) begin
      err_r <= RESULT_CLAMPED_I || missing_reference_flag_s;
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      data_r <= '0;
      chan_r <= '0;
    end else if (RESULT_WRITE_I) begin
      data_r <= missing_reference_flag_s ? '1 : RESULT_DATA_I;
      chan_r <= RESULT_CHANNEL_I;
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      parity_r <= 1'b0;
    end else begin
      parity_r <= PARITY_CHECK_ENABLE_I && (^data_r);
    end
  end

  assign status = {rdy_n_r, err_r, missing_reference_flag_s, parity_r, chan_r};

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      DOUT_RDY_N_O <= 1'b1;
      STATUS_O <= `CST_RESET;
      DATA_O <= '0;
    end else begin
      DOUT_RDY_N_O <= dout_r;
      STATUS_O <= status;
      DATA_O <= data_r;
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  sequence s_new_result;
    RESULT_WRITE_I;
  endsequence

  sequence s_idle_request;
    !RESULT_WRITE_I && (POWER_IDLE_I || !sync_n_s);
  endsequence

  a_rdy_new_clear: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    s_new_result |=> !rdy_n_r ##1 (STATUS_O[`CST_RDY_BIT] == 1'b0))
    else $error("ready bit not cleared by new result");

  a_rdy_read_set: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    (data_read_done || UPDATE_WARN_I) && !RESULT_WRITE_I |=> rdy_n_r)
    else $error("ready bit not set after data read or warning");

  a_rdy_idle_set: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    s_idle_request |=> rdy_n_r)
    else $error("ready bit not set on idle or sync");

  a_err_result: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    s_new_result ##0 !CAL_ACTIVE_I |=> err_r == ($past(RESULT_CLAMPED_I) || $past(missing_reference_flag_s)))
    else $error("error flag does not track clamped result");

  a_missing_reference_flag_clamp: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    s_new_result ##0 missing_reference_flag_s |=> (data_r == '1) && err_r)
    else $error("result not clamped while reference missing");

  a_parity_value: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    s_new_result ##1 !RESULT_WRITE_I ##0 PARITY_CHECK_ENABLE_I |=> parity_r == (^data_r))
    else $error("parity flag wrong for held data");

  a_shift_msb: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    (state_r == LINK_SEND) && sclk_fall |=> dout_r == $past(tx_r[31]))
    else $error("serial output not taken from top bit");

  a_pin_ready: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    (state_r == LINK_WAIT) |=> ##1 DOUT_RDY_N_O == $past(rdy_n_r, 2))
    else $error("pin does not show ready between transfers");

  a_append_len: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    (state_r == LINK_CMD) && sclk_rise && (cnt_r == 6'h01) && cmd_nxt[6] &&
    (rsel_nxt == `RSEL_DATA) && APPEND_STATUS_ENABLE_I |=> cnt_r == `SIZE_APPENDED)
    else $error("status not appended to data read");

  a_chan_tag: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    s_new_result |=> ##1 STATUS_O[`CST_CHAN_MSB:0] == $past(RESULT_CHANNEL_I, 2))
    else $error("channel tag does not follow result");

  a_wait_zero: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    (state_r == LINK_WAIT) && sclk_rise && din_s |=> state_r == LINK_WAIT)
    else $error("leading one started a command");
endmodule
`default_nettype wire

// File: sim/host_link_model.sv
// Host side of the serial link: makes the link clock, shifts commands in and results out.
`default_nettype none
module host_link_model (
  output logic sclk_o,
  output logic din_o,
  input wire logic dout_i
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sclk_o = 1'b1;
    din_o = 1'b1;
  end
  // ---------------------------------------------------------------------------
  // Bit and frame transfers
  // ---------------------------------------------------------------------------
  // The answer bit lands late in the low phase, so it is taken halfway into the high phase.
  task automatic bit_xfer(input logic b, output logic r);
    sclk_o = 1'b0;
    din_o = b;
    #100;
    sclk_o = 1'b1;
    #50;
    r = dout_i;
    #50;
  endtask
  task automatic xfer(input int lead, input logic [7:0] cmd, input int n,
                      output logic [31:0] rd);
    logic r;
    rd = '0;
    #7;
    for (int i = 0; i < lead; i++) bit_xfer(1'b1, r);
    for (int i = 7; i >= 0; i--) bit_xfer(cmd[i], r);
    for (int i = 0; i < n; i++) begin
      bit_xfer(1'b1, r);
      rd = {rd[30:0], r};
    end
    din_o = 1'b1;
  endtask
endmodule
`default_nettype wire

// File: sim/adc_status_register_tb_top.sv
// Self-checking bench for the converter status register and its serial read path.
`default_nettype none
module adc_status_register_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst, sync_n, ref_below, res_wr, clamped, warn, idle;
  logic cal_act, cal_sys, cal_ref, cal_rng, par_en, app_en, dout;
  logic [23:0] res_data, data_o, exp_data;
  logic [3:0] chan;
  logic [7:0] status, exp_st;
  logic [31:0] rd, r;
  logic [31:0] seed = 32'hcd9badf6;
  wire sclk, din;
  int error_cnt = 0;
  int tests_run = 0;
  converter_status converter_status_i (.REF_CLK_I(clk), .RST_I(rst), .SCLK_I(sclk),
    .DIN_I(din), .SYNC_N_I(sync_n), .REF_BELOW_I(ref_below), .RESULT_WRITE_I(res_wr),
    .RESULT_DATA_I(res_data), .RESULT_CLAMPED_I(clamped), .RESULT_CHANNEL_I(chan),
    .UPDATE_WARN_I(warn), .POWER_IDLE_I(idle), .CAL_ACTIVE_I(cal_act),
    .CAL_SYSTEM_I(cal_sys), .CAL_REF_BAD_I(cal_ref), .CAL_RANGE_BAD_I(cal_rng),
    .PARITY_CHECK_ENABLE_I(par_en), .APPEND_STATUS_ENABLE_I(app_en),
    .DOUT_RDY_N_O(dout), .STATUS_O(status), .DATA_O(data_o));
  host_link_model host_link_model_i (.sclk_o(sclk), .din_o(din), .dout_i(dout));
  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [7:0] expect_status(input logic cl, input logic rb,
                                               input logic [23:0] d, input logic [3:0] ch);
    return {1'b0, cl | rb, rb, par_en & ^d, ch};
  endfunction
  task automatic chk_st(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_w(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // The reference level settles through its synchroniser before the result lands.
  task automatic result(input logic [23:0] d, input logic cl, input logic [3:0] ch,
                        input logic rb);
    ref_below = rb;
    tick(4);
    res_data = d;
    clamped = cl;
    chan = ch;
    res_wr = 1'b1;
    tick(1);
    res_wr = 1'b0;
    tick(3);
    exp_data = rb ? 24'hffffff : d;
    exp_st = expect_status(cl, rb, exp_data, ch);
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------------------
  // Clock, timeout and main sequence
  // ---------------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    finish_test();
  end
  initial begin
    {rst, sync_n} = 2'b11;
    {ref_below, res_wr, clamped, warn, idle, cal_act, cal_sys, cal_ref} = 8'h00;
    {cal_rng, par_en, app_en, res_data, chan} = '0;
    tick(2);
    chk_st("reset status", 8'h80, status);
    rst = 1'b0;
    tick(4);
    for (int k = 0; k < 8; k++) begin
      r = xs();
      par_en = r[0];
      app_en = r[1] | r[0];
      result(r[31:8], r[2] & (k != 4), r[7:4], k == 3);
      chk_st("status", exp_st, status);
      chk_w("data out", {8'h0, exp_data}, {8'h0, data_o});
      chk_w("ready pin", 32'h0, {31'h0, dout});
      host_link_model_i.xfer(k % 3, 8'h40, 8, rd);
      chk_st("serial status", exp_st, rd[7:0]);
      host_link_model_i.xfer(0, 8'h58, app_en ? 32 : 24, rd);
      chk_w("serial data", app_en ? {exp_data, exp_st} : {8'h0, exp_data}, rd);
      tick(4);
      chk_st("after read", exp_st | 8'h80, status);
    end
    for (int s = 0; s < 3; s++) begin
      result(24'h000001, 1'b0, 4'h2, 1'b0);
      case (s)
        0: warn = 1'b1;
        1: idle = 1'b1;
        default: sync_n = 1'b0;
      endcase
      tick(1);
      warn = 1'b0;
      tick(4);
      chk_st("ready set", exp_st | 8'h80, status);
      chk_w("ready pin idle", 32'h1, {31'h0, dout});
      idle = 1'b0;
      sync_n = 1'b1;
    end
    for (int s = 0; s < 2; s++) begin
      result(24'h0000f0, 1'b0, 4'h1, 1'b0);
      {cal_act, cal_ref, cal_sys, cal_rng} = {1'b1, s == 0, s == 1, s == 1};
      tick(5);
      chk_st("cal error", exp_st | 8'h40, status);
      {cal_act, cal_ref, cal_sys, cal_rng} = 4'h0;
    end
    result(24'h000003, 1'b0, 4'h1, 1'b0);
    chk_st("error cleared", exp_st, status);
    host_link_model_i.xfer(0, 8'h00, 0, rd);
    host_link_model_i.xfer(0, 8'h08, 24, rd);
    tick(4);
    chk_st("after writes", exp_st, status);
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    tick(1);
    chk_st("status after reset", 8'h80, status);
    chk_w("data after reset", 32'h0, {8'h0, data_o});
    chk_w("pin after reset", 32'h1, {31'h0, dout});
    tick(4);
    chk_st("status settled", 8'h80, status);
    finish_test();
  end
endmodule
`default_nettype wire
